// ==== rtl/config_pin_function_mux.sv ====
// Purpose: selects the function driven onto or read from each config pin
// Assumes: status inputs come from logic on clk_sys; pins are asynchronous
// Notes:   pins float until the nonvolatile codes have been taken
//
// Overview of operation
// - any pin may float, drive 1 or 0
// - line driver enable follows transmitter busy
// - power indicator low once configured, high suspended
// - send activity gives active-low pulses
// - receive activity gives active-low pulses
// - combined activity pulses on either direction
// - sleep indicator low throughout suspend
// - divided clocks out, stopped during suspend
// - up to four pins as gpio
// - function held separately for each pin
// - charger detect high on dedicated charger
// - inverted charger detect is exact complement
// - pin may present port write strobe
// - pin may present port read strobe
// - bus-power sense is a sampled input
// - frame marker toggles per start of frame
// - keep-awake input low blocks suspend entry
// - factory defaults per pin
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module config_pin_function_mux
   import pin_mux_pkg::*;
#(
   parameter int PULSE_CYCLES = LED_PULSE_CYCLES
)(
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [NPINS*FW-1:0] nv_config,
   input  wire logic                nv_ready,
   input  wire logic                nv_blank,
   input  wire logic                tx_busy,
   input  wire logic                usb_configured,
   input  wire logic                usb_suspend,
   input  wire logic                usb_send_act,
   input  wire logic                usb_recv_act,
   input  wire logic                charger_port,
   input  wire logic                port_write_strobe_n,
   input  wire logic                port_read_strobe_n,
   input  wire logic                sof_pulse,
   input  wire logic                ref_tick_48,
   input  wire logic [NPINS-1:0]    config_pin_in,
   output logic      [NPINS-1:0]    config_pin_out,
   output logic      [NPINS-1:0]    config_pin_oe,
   output logic                     vbus_present,
   output logic                     keep_awake
);

   typedef struct packed
   {
      logic [NPINS-1:0][FW-1:0] func;
      logic                     loaded;
      logic [NPINS-1:0]         gpio_val;
      logic [NPINS-1:0]         gpio_dir;
      logic [NPINS-1:0]         sync1;
      logic [NPINS-1:0]         sync2;
      logic [CLKDIV_W-1:0]      clkdiv;
      logic                     frame;
      logic [NPINS-1:0]         pin_out;
      logic [NPINS-1:0]         pin_oe;
      logic                     vbus;
      logic                     awake;
      logic                     wr_pend;
      logic [7:0]               wr_addr;
      logic [31:0]              rdata;
      logic                     ready;
   } mux_state_t;

   mux_state_t q;
   mux_state_t next_q;
   logic       send_led_n;
   logic       recv_led_n;
   logic       any_led_n;
   logic       act_any;
   logic       addr_ok;
   logic [7:0] word_addr;

   assign act_any   = usb_send_act | usb_recv_act;
   assign addr_ok   = hsel & hready & htrans[HTRANS_ACT_BIT];
   assign word_addr = {haddr[7:2], 2'b00};

   // one stretcher per activity indicator
   activity_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_send_led
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .trig    (usb_send_act),
      .led_n   (send_led_n)
   );
   activity_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_recv_led
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .trig    (usb_recv_act),
      .led_n   (recv_led_n)
   );
   activity_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_any_led
   (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .trig    (act_any),
      .led_n   (any_led_n)
   );

   // all next-state logic
   always_comb
   begin
      next_q = q;
      // two-stage pin synchroniser; stage one feeds stage two only
      next_q.sync1 = config_pin_in;
      next_q.sync2 = q.sync1;

      // divider held at zero so suspended clocks sit low
      if (usb_suspend)
      begin
         next_q.clkdiv = '0;
      end
      else if (ref_tick_48)
      begin
         next_q.clkdiv = q.clkdiv + CLKDIV_W'(1);
      end

      if (sof_pulse)
      begin
         next_q.frame = ~q.frame;
      end

      // data phase of a write
      if (q.wr_pend)
      begin
         unique case (q.wr_addr)
            ADDR_PIN_FUNC:
            begin
               for (int i = 0; i < NPINS; i++)
               begin
                  next_q.func[i] = hwdata[i*FUNC_STRIDE +: FW];
               end
            end
            ADDR_GPIO:
            begin
               next_q.gpio_val = hwdata[NPINS-1:0];
               next_q.gpio_dir = hwdata[GPIO_DIR_LSB +: NPINS];
            end
            ADDR_RELOAD:
            begin
               if (hwdata[RELOAD_BIT])
               begin
                  next_q.loaded = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end

      // nonvolatile load comes last so it wins over a clear or a write
      if (!q.loaded && nv_ready)
      begin
         if (!nv_blank)
         begin
            for (int i = 0; i < NPINS; i++)
            begin
               next_q.func[i] = nv_config[i*FW +: FW];
            end
         end
         next_q.loaded = 1'b1;
      end

      // address phase; zero wait states so data is ready next cycle
      next_q.wr_pend = addr_ok & hwrite;
      next_q.wr_addr = word_addr;
      next_q.rdata   = '0;
      if (addr_ok && !hwrite)
      begin
         unique case (word_addr)
            ADDR_PIN_FUNC:
            begin
               for (int i = 0; i < NPINS; i++)
               begin
                  next_q.rdata[i*FUNC_STRIDE +: FW] = q.func[i];
               end
            end
            ADDR_GPIO:
            begin
               next_q.rdata[NPINS-1:0] = q.gpio_val;
               next_q.rdata[GPIO_DIR_LSB +: NPINS] = q.gpio_dir;
            end
            ADDR_STATUS:
            begin
               next_q.rdata[NPINS-1:0]       = q.sync2;
               next_q.rdata[STAT_VBUS_BIT]   = q.vbus;
               next_q.rdata[STAT_AWAKE_BIT]  = q.awake;
               next_q.rdata[STAT_LOADED_BIT] = q.loaded;
            end
            default:
            begin
            end
         endcase
      end
      next_q.ready = 1'b1;

      // per-pin selection, each pin from its own code
      next_q.vbus  = 1'b0;
      next_q.awake = 1'b0;
      for (int i = 0; i < NPINS; i++)
      begin
         next_q.pin_out[i] = 1'b0;
         next_q.pin_oe[i]  = 1'b1;
         unique case (q.func[i])
            FN_TRISTATE:   next_q.pin_oe[i] = 1'b0;
            FN_DRIVE1:     next_q.pin_out[i] = 1'b1;
            FN_DRIVE0:     next_q.pin_out[i] = 1'b0;
            FN_LINE_DRV:   next_q.pin_out[i] = tx_busy;
            FN_PWR_IND:    next_q.pin_out[i] = ~(usb_configured & ~usb_suspend);
            FN_SEND_LED:   next_q.pin_out[i] = send_led_n;
            FN_RECV_LED:   next_q.pin_out[i] = recv_led_n;
            FN_ANY_LED:    next_q.pin_out[i] = any_led_n;
            FN_SLEEP_IND:  next_q.pin_out[i] = ~usb_suspend;
            FN_CLK_FAST:   next_q.pin_out[i] = q.clkdiv[0];
            FN_CLK_MID:    next_q.pin_out[i] = q.clkdiv[1];
            FN_CLK_SLOW:   next_q.pin_out[i] = q.clkdiv[2];
            FN_GPIO:
            begin
               next_q.pin_out[i] = q.gpio_val[i];
               next_q.pin_oe[i]  = q.gpio_dir[i];
            end
            FN_CHARGER:    next_q.pin_out[i] = charger_port;
            FN_CHARGER_N:  next_q.pin_out[i] = ~charger_port;
            FN_WR_STROBE:  next_q.pin_out[i] = port_write_strobe_n;
            FN_RD_STROBE:  next_q.pin_out[i] = port_read_strobe_n;
            FN_VBUS_SENSE:
            begin
               next_q.pin_oe[i] = 1'b0;
               if (q.loaded && q.sync2[i])
               begin
                  next_q.vbus = 1'b1;
               end
            end
            FN_FRAME_MARK: next_q.pin_out[i] = q.frame;
            FN_KEEP_AWAKE:
            begin
               next_q.pin_oe[i] = 1'b0;
               if (q.loaded && !q.sync2[i])
               begin
                  next_q.awake = 1'b1;
               end
            end
            default:       next_q.pin_oe[i] = 1'b0;
         endcase
         if (!q.loaded)
         begin
            next_q.pin_oe[i]  = 1'b0;
            next_q.pin_out[i] = 1'b0;
         end
      end
   end

   // reset leaves factory codes in place until the load arrives
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q        <= '0;
         q.func   <= FUNC_DEFAULT;
         q.ready  <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign hrdata         = q.rdata;
   assign hreadyout      = q.ready;
   assign hresp          = 1'b0;
   assign config_pin_out = q.pin_out;
   assign config_pin_oe  = q.pin_oe;
   assign vbus_present   = q.vbus;
   assign keep_awake     = q.awake;

   // checks, watching pin 0, except pin 1 for the clock stop and all pins for floating before load
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   logic [FW-1:0] f0;
   logic          l0;
   assign f0 = q.func[0];
   assign l0 = q.loaded;

   sequence vbus_sel_held;
      (l0 && f0 == FN_VBUS_SENSE) [*4];
   endsequence

   sequence sof_on_mark;
      sof_pulse && l0 && f0 == FN_FRAME_MARK ##1 l0 && f0 == FN_FRAME_MARK;
   endsequence

   chk_float_unloaded: assert property (!l0 [*2] |-> q.pin_oe == '0)
      else $error("pin driven before codes loaded");
   chk_drive_high: assert property ($past(l0 && f0 == FN_DRIVE1)
      |-> q.pin_oe[0] && q.pin_out[0])
      else $error("constant high not driven");
   chk_line_driver: assert property ($past(l0 && f0 == FN_LINE_DRV)
      |-> q.pin_out[0] == $past(tx_busy))
      else $error("line driver enable wrong");
   chk_power_ind: assert property ($past(l0 && f0 == FN_PWR_IND)
      |-> q.pin_out[0] == !$past(usb_configured && !usb_suspend))
      else $error("power indicator wrong");
   chk_sleep_ind: assert property ($past(l0 && f0 == FN_SLEEP_IND && usb_suspend)
      |-> q.pin_oe[0] && !q.pin_out[0])
      else $error("sleep indicator high in suspend");
   chk_send_led: assert property (usb_send_act && l0 && f0 == FN_SEND_LED
      ##1 (l0 && f0 == FN_SEND_LED) |-> ##[0:2] !q.pin_out[0])
      else $error("send activity gave no pulse");
   chk_clk_stop: assert property (usb_suspend
      ##1 (usb_suspend && l0 && q.func[1] == FN_CLK_FAST) |=> !q.pin_out[1])
      else $error("clock output running in suspend");
   chk_charger_inv: assert property ($past(l0 && f0 == FN_CHARGER_N)
      |-> q.pin_out[0] == !$past(charger_port))
      else $error("inverted charger flag wrong");
   chk_input_undriven: assert property ($past(l0 && f0 == FN_VBUS_SENSE)
      |-> !q.pin_oe[0])
      else $error("input option drives pin");
   chk_vbus_sense: assert property (vbus_sel_held
      |-> vbus_present == $past(config_pin_in[0], 3))
      else $error("bus power sense not following pin");
   chk_frame_toggle: assert property (sof_on_mark |=> q.pin_out[0] != $past(q.pin_out[0]))
      else $error("frame marker did not toggle");

endmodule
`default_nettype wire

// ==== include/pin_mux_pkg.sv ====
// Purpose: shared constants for the configurable pin function selector
// Assumes: one 125 MHz system clock, AHB-Lite register access
// Notes:   function codes are 5 bits wide, one field per pin
package pin_mux_pkg;

   localparam int NPINS = 4;
   localparam int FW    = 5;

   // per-pin function codes
   localparam logic [4:0] FN_TRISTATE   = 5'h00;
   localparam logic [4:0] FN_DRIVE1     = 5'h01;
   localparam logic [4:0] FN_DRIVE0     = 5'h02;
   localparam logic [4:0] FN_LINE_DRV   = 5'h03;
   localparam logic [4:0] FN_PWR_IND    = 5'h04;
   localparam logic [4:0] FN_SEND_LED   = 5'h05;
   localparam logic [4:0] FN_RECV_LED   = 5'h06;
   localparam logic [4:0] FN_ANY_LED    = 5'h07;
   localparam logic [4:0] FN_SLEEP_IND  = 5'h08;
   localparam logic [4:0] FN_CLK_FAST   = 5'h09;
   localparam logic [4:0] FN_CLK_MID    = 5'h0a;
   localparam logic [4:0] FN_CLK_SLOW   = 5'h0b;
   localparam logic [4:0] FN_GPIO       = 5'h0c;
   localparam logic [4:0] FN_CHARGER    = 5'h0d;
   localparam logic [4:0] FN_CHARGER_N  = 5'h0e;
   localparam logic [4:0] FN_WR_STROBE  = 5'h0f;
   localparam logic [4:0] FN_RD_STROBE  = 5'h10;
   localparam logic [4:0] FN_VBUS_SENSE = 5'h11;
   localparam logic [4:0] FN_FRAME_MARK = 5'h12;
   localparam logic [4:0] FN_KEEP_AWAKE = 5'h13;

   // factory assignment per pin
   localparam logic [NPINS-1:0][FW-1:0] FUNC_DEFAULT =
      {FN_SLEEP_IND, FN_SEND_LED, FN_RECV_LED, FN_LINE_DRV};

   // register byte addresses and field layout
   localparam logic [7:0] ADDR_PIN_FUNC = 8'h00;
   localparam logic [7:0] ADDR_GPIO     = 8'h04;
   localparam logic [7:0] ADDR_STATUS   = 8'h08;
   localparam logic [7:0] ADDR_RELOAD   = 8'h0c;
   localparam int FUNC_STRIDE     = 8;
   localparam int GPIO_DIR_LSB    = 8;
   localparam int STAT_VBUS_BIT   = 8;
   localparam int STAT_AWAKE_BIT  = 9;
   localparam int STAT_LOADED_BIT = 10;
   localparam int RELOAD_BIT      = 0;
   localparam int HTRANS_ACT_BIT  = 1;

   // timing
   localparam int CLK_SYS_MHZ      = 125;
   localparam int LED_PULSE_US     = 1000;
   localparam int LED_PULSE_CYCLES = LED_PULSE_US * CLK_SYS_MHZ;
   localparam int CLKDIV_W         = 3;

endpackage

// ==== rtl/activity_pulse.sv ====
// Purpose: stretches a one-cycle activity strobe into a visible low pulse
// Assumes: trig is a pulse on clk_sys
// Notes:   steady activity keeps the output low rather than blinking
`timescale 1ns/1ps
`default_nettype none
module activity_pulse
   import pin_mux_pkg::*;
#(
   parameter int PULSE_CYCLES = LED_PULSE_CYCLES
)(
   input  wire logic clk_sys,
   input  wire logic sys_rst,
   input  wire logic trig,
   output logic      led_n
);

   localparam int CW = $clog2(PULSE_CYCLES + 1);

   typedef struct packed
   {
      logic [CW-1:0] cnt;
      logic          led_n;
   } ap_state_t;

   ap_state_t q;
   ap_state_t next_q;

   // retrigger restarts the full pulse
   always_comb
   begin
      next_q = q;
      if (trig)
      begin
         next_q.cnt = CW'(PULSE_CYCLES);
      end
      else if (q.cnt != '0)
      begin
         next_q.cnt = q.cnt - CW'(1);
      end
      next_q.led_n = (next_q.cnt == '0);
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         q <= '{cnt: '0, led_n: 1'b1};
      end
      else
      begin
         q <= next_q;
      end
   end

   assign led_n = q.led_n;

endmodule
`default_nettype wire

// ==== sim/pin_side_model.sv ====
// Purpose: board side of the four config pins
// Assumes: a weak pull on every pin, pulled low in suspend
// Notes:   a released pin goes to the board driver if enabled, else its pull level, never its last value
`timescale 1ns/1ps
`default_nettype none
module pin_side_model
   import pin_mux_pkg::*;
(
   input  wire logic [NPINS-1:0] pin_out,
   input  wire logic [NPINS-1:0] pin_oe,
   input  wire logic [NPINS-1:0] ext_en,
   input  wire logic [NPINS-1:0] ext_lvl,
   input  wire logic             pull_down,
   output logic      [NPINS-1:0] pin_lvl
);
   // device drive wins, then the board driver, then the pull resistor
   always_comb
   begin
      for (int i = 0; i < NPINS; i++)
      begin
         if (pin_oe[i])
            pin_lvl[i] = pin_out[i];
         else if (ext_en[i])
            pin_lvl[i] = ext_lvl[i];
         else
            pin_lvl[i] = !pull_down; // keeps a floated switch off
      end
   end
endmodule
`default_nettype wire

// ==== sim/config_pin_function_mux_tb_top.sv ====
// Purpose: self-checking bench for the config pin selector
// Assumes: zero-wait bus, led pulse cut to 8 cycles
// Notes:   expected values come from bench functions and fixed constants
`timescale 1ns/1ps
`default_nettype none
module config_pin_function_mux_tb_top
   import pin_mux_pkg::*;
;
   localparam int PC = 8;
   logic        clk_sys, sys_rst, hsel, hwrite, hreadyout, hresp, v, a;
   logic        nv_ready, nv_blank, tx_busy, usb_configured, usb_suspend, sof_pulse;
   logic        usb_send_act, usb_recv_act, charger_port, wr_n, rd_n, ref_tick_48;
   logic        vbus_present, keep_awake;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [19:0] nv_config;
   logic [3:0]  pin_lvl, pin_out, pin_oe, ext_en, ext_lvl, gv, gd, pp;
   logic [4:0]  fc [4];
   logic [4:0]  st [15];
   logic [7:0]  cnt [4];
   logic [15:0] seed;
   int          n_errors = 0, checks_done = 0, cyc = 0;

   config_pin_function_mux #(.PULSE_CYCLES(PC)) i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .nv_config(nv_config), .nv_ready(nv_ready),
      .nv_blank(nv_blank), .tx_busy(tx_busy), .usb_configured(usb_configured),
      .usb_suspend(usb_suspend), .usb_send_act(usb_send_act), .usb_recv_act(usb_recv_act),
      .charger_port(charger_port), .port_write_strobe_n(wr_n), .port_read_strobe_n(rd_n),
      .sof_pulse(sof_pulse), .ref_tick_48(ref_tick_48), .config_pin_in(pin_lvl),
      .config_pin_out(pin_out), .config_pin_oe(pin_oe), .vbus_present(vbus_present),
      .keep_awake(keep_awake));

   pin_side_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_lvl(ext_lvl), .pull_down(usb_suspend), .pin_lvl(pin_lvl));

   // 125 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // hang guard, far above the roughly 700 cycles the run needs
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_errors++;
         complete_run();
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // expected {drive enable, level} of a pin from its code
   function automatic logic [1:0] exp_pin(input logic [4:0] c, input int i);
      case (c)
         FN_DRIVE1, FN_SEND_LED, FN_RECV_LED, FN_ANY_LED: return 2'b11; // leds idle high
         FN_DRIVE0:    return 2'b10;
         FN_LINE_DRV:  return {1'b1, tx_busy};
         FN_PWR_IND:   return {1'b1, !(usb_configured && !usb_suspend)};
         FN_SLEEP_IND: return {1'b1, !usb_suspend};
         FN_GPIO:      return {gd[i], gv[i]};
         FN_CHARGER:   return {1'b1, charger_port};
         FN_CHARGER_N: return {1'b1, !charger_port};
         FN_WR_STROBE: return {1'b1, wr_n};
         FN_RD_STROBE: return {1'b1, rd_n};
         default:      return 2'b00; // float, input options, unused codes
      endcase
   endfunction

   // level on the wire, pull follows suspend
   function automatic logic lvl(input int i);
      logic [1:0] e;
      e = exp_pin(fc[i], i);
      return e[1] ? e[0] : (ext_en[i] ? ext_lvl[i] : !usb_suspend);
   endfunction

   function automatic logic [31:0] pack();
      return {3'h0, fc[3], 3'h0, fc[2], 3'h0, fc[1], 3'h0, fc[0]};
   endfunction

   task automatic cmp_bit(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask

   // one single-word transfer; read data lands in r
   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge clk_sys);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, ad};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      {htrans, hwdata} <= {2'h0, wd};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
      ahb(1'b0, ad, 32'h0);
      cmp_word(r, e);
      // zero-wait slave, response always okay
      cmp_word({30'h0, hreadyout, hresp}, 32'h2);
   endtask

   task automatic set_fc();
      ahb(1'b1, ADDR_PIN_FUNC, pack());
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic drive_rand();
      seed = lfsr(seed);
      {tx_busy, usb_configured, usb_suspend, charger_port, wr_n, rd_n} <= seed[5:0];
   endtask

   task automatic check_pins();
      logic [1:0] e;
      for (int i = 0; i < NPINS; i++)
      begin
         e = exp_pin(fc[i], i);
         cmp_bit(pin_oe[i], e[1]);
         if (e[1])
            cmp_bit(pin_out[i], e[0]);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      {sys_rst, hsel, htrans, hwrite, hsize, haddr, hwdata} = {5'h10, 3'h2, 64'h0};
      {nv_config, ext_en, ext_lvl, gv, gd} = '0;
      {nv_ready, nv_blank, tx_busy, usb_configured, usb_suspend, sof_pulse} = '0;
      {usb_send_act, usb_recv_act, charger_port, wr_n, rd_n, ref_tick_48} = '0;
      seed = 16'h99c7; // start value 39367
      st = '{FN_TRISTATE, FN_DRIVE1, FN_DRIVE0, FN_LINE_DRV, FN_PWR_IND, FN_SLEEP_IND,
             FN_GPIO, FN_CHARGER, FN_CHARGER_N, FN_WR_STROBE, FN_RD_STROBE,
             FN_VBUS_SENSE, FN_KEEP_AWAKE, 5'h14, 5'h1f};
      fc = '{FN_LINE_DRV, FN_RECV_LED, FN_SEND_LED, FN_SLEEP_IND};
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      cmp_word({28'h0, pin_oe}, 32'h0);
      rchk(ADDR_PIN_FUNC, 32'h08050603);
      rchk(8'h10, 32'h0);
      rchk(ADDR_STATUS, 32'h0000000f);
      {nv_blank, nv_ready} <= 2'b11;
      drive_rand();
      repeat (4) @(posedge clk_sys);
      #1;
      check_pins();
      $display("test defaults done");
      // reload: pins float until fresh codes are ready
      nv_ready <= 1'b0;
      ahb(1'b1, ADDR_RELOAD, 32'h1);
      repeat (3) @(posedge clk_sys);
      #1;
      cmp_word({28'h0, pin_oe}, 32'h0);
      for (int i = 0; i < NPINS; i++)
      begin
         seed = lfsr(seed);
         fc[i] = st[seed % 15];
      end
      nv_config <= {fc[3], fc[2], fc[1], fc[0]};
      {nv_blank, nv_ready} <= 2'b01;
      repeat (4) @(posedge clk_sys);
      #1;
      check_pins();
      rchk(ADDR_PIN_FUNC, pack());
      $display("test reload done");
      // each pin a different code, rotated through the static options
      for (int k = 0; k < 15; k++)
      begin
         seed = lfsr(seed);
         {gd, gv, ext_lvl} <= seed[11:0];
         for (int i = 0; i < NPINS; i++)
         begin
            fc[i] = st[(k + i) % 15];
            ext_en[i] <= fc[i] == FN_VBUS_SENSE || fc[i] == FN_KEEP_AWAKE;
         end
         ahb(1'b1, ADDR_GPIO, {20'h0, seed[11:8], 4'h0, seed[7:4]});
         set_fc();
         ahb(1'b1, 8'h14, 32'hffffffff);
         rchk(ADDR_PIN_FUNC, pack());
         rchk(ADDR_GPIO, {20'h0, seed[11:8], 4'h0, seed[7:4]});
         repeat (6)
         begin
            @(posedge clk_sys);
            drive_rand();
            @(posedge clk_sys);
            #1;
            check_pins();
         end
         repeat (4) @(posedge clk_sys);
         {v, a} = '0;
         for (int i = 0; i < NPINS; i++)
         begin
            v |= fc[i] == FN_VBUS_SENSE && lvl(i);
            a |= fc[i] == FN_KEEP_AWAKE && !lvl(i);
         end
         #1;
         cmp_bit(vbus_present, v);
         cmp_bit(keep_awake, a);
         rchk(ADDR_STATUS, {21'h0, 1'b1, a, v, 4'h0, lvl(3), lvl(2), lvl(1), lvl(0)});
      end
      $display("test static codes done");
      // one activity strobe per direction, pulse length checked at both ends
      {ext_en, usb_suspend} <= '0;
      fc = '{FN_SEND_LED, FN_RECV_LED, FN_ANY_LED, FN_DRIVE1};
      set_fc();
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk_sys);
         {usb_send_act, usb_recv_act} <= s ? 2'b01 : 2'b10;
         @(posedge clk_sys);
         {usb_send_act, usb_recv_act} <= 2'b00;
         @(posedge clk_sys);
         #1;
         cmp_word({28'h0, pin_out}, s ? 32'h9 : 32'ha);
         repeat (PC - 1) @(posedge clk_sys);
         #1;
         cmp_word({28'h0, pin_out}, s ? 32'h9 : 32'ha);
         repeat (2) @(posedge clk_sys);
         #1;
         cmp_word({28'h0, pin_out}, 32'hf);
      end
      $display("test leds done");
      // count edges: divider bits halve, frame marker once per sof
      fc = '{FN_FRAME_MARK, FN_CLK_FAST, FN_CLK_MID, FN_CLK_SLOW};
      set_fc();
      #1;
      pp = pin_out;
      cnt = '{8'h0, 8'h0, 8'h0, 8'h0};
      for (int j = 0; j < 40; j++)
      begin
         @(posedge clk_sys);
         ref_tick_48 <= j < 32 && j % 2 == 0;
         sof_pulse <= j < 32 && j % 5 == 0;
         #1;
         for (int i = 0; i < NPINS; i++)
            cnt[i] += 8'(pin_out[i] != pp[i]);
         pp = pin_out;
      end
      cmp_word({cnt[3], cnt[2], cnt[1], cnt[0]}, 32'h04081007);
      usb_suspend <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (int j = 0; j < 8; j++)
      begin
         @(posedge clk_sys);
         ref_tick_48 <= j % 2 == 0;
         #1;
         cmp_word({29'h0, pin_out[3:1]}, 32'h0);
      end
      $display("test clocks and frame marker done");
      complete_run();
   end
endmodule
`default_nettype wire
